/* hdl/sifl_params.svh */
// Constants of the servo integral and feed-forward loop
`ifndef SIFL_PARAMS_SVH
`define SIFL_PARAMS_SVH
// =====================================================
// Register byte offsets
`define SIFL_OFS_CTRL      12'h000
`define SIFL_OFS_PROPORTIONAL_GAIN     12'h004
`define SIFL_OFS_INTEGRAL_GAIN      12'h008
`define SIFL_OFS_KCLAMP    12'h00c
`define SIFL_OFS_KVFF      12'h010
`define SIFL_OFS_POSITION  12'h014
`define SIFL_OFS_FERROR    12'h018
`define SIFL_OFS_DEMAND    12'h01c
`define SIFL_OFS_INTEG     12'h020
`define SIFL_OFS_COMMAND   12'h024
// =====================================================
// Field positions
`define SIFL_CTRL_MODE_LSB   0
`define SIFL_CTRL_MODE_MSB   1
`define SIFL_CTRL_PER_LSB    4
`define SIFL_CTRL_PER_MSB    6
`define SIFL_CMD_CLR_INTEG   0
`define SIFL_CMD_CLR_POS     1
// =====================================================
// Reset values and codes
`define SIFL_RST_GAIN        16'h0000
`define SIFL_RST_PCT         8'h00
`define SIFL_RST_MODE        2'h1
`define SIFL_RST_PERIOD      3'h0
`define SIFL_MODE_NEVER      2'h0
`define SIFL_MODE_ALWAYS     2'h1
`define SIFL_MODE_SMART      2'h2
`define SIFL_MODE_STEADY     2'h3
`define SIFL_PER_1MS         3'h0
`define SIFL_PER_2MS         3'h1
`define SIFL_PER_500US       3'h2
`define SIFL_PER_200US       3'h3
`define SIFL_PER_100US       3'h4
// =====================================================
// Arithmetic scaling
`define SIFL_FULL_SCALE      2048
`define SIFL_OUT_MAX         2047
`define SIFL_OUT_MIN         (-2048)
`define SIFL_PCT_FULL        100
`define SIFL_GAIN_FRAC       8
// =====================================================
// Timing
`define SIFL_CLK_PERIOD_NS   25
`define SIFL_T_2MS_NS        2000000
`define SIFL_T_1MS_NS        1000000
`define SIFL_T_500US_NS      500000
`define SIFL_T_200US_NS      200000
`define SIFL_T_100US_NS      100000
`endif

/* hdl/sifl_pkg.sv */
// Types shared by the servo loop files
package sifl_pkg;
  typedef logic [1:0] sifl_imode_t;
  typedef logic [2:0] sifl_period_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sifl_apb_req_t;
  typedef struct packed {
    logic [15:0]  proportional_gain;
    logic [15:0]  integral_gain;
    logic [7:0]   clamp_pct;
    logic [15:0]  kvff;
    sifl_imode_t  imode;
    sifl_period_t period;
  } sifl_gains_t;
endpackage

/* hdl/sifl_quad_decoder.sv */
// Quadrature decoder: synchronises the encoder pins and emits count steps
`timescale 1ns/1ps
`include "sifl_params.svh"
module sifl_quad_decoder
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic enc_a,
  input  wire logic enc_b,
  output logic      step_up,
  output logic      step_dn
);
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] prev;
  logic       fwd;
  logic       rev;

  // =====================================================
  // Pin synchroniser; sync1 is read only by sync2
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      prev  <= 2'h0;
    end
    else if (ce)
    begin
      sync1 <= {enc_a, enc_b};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // =====================================================
  // Each edge of either channel is one step; A leading B counts up
  // A jump of both channels at once has no direction and is dropped
  assign fwd = (prev == 2'h0 && sync2 == 2'h2) || (prev == 2'h2 && sync2 == 2'h3) ||
               (prev == 2'h3 && sync2 == 2'h1) || (prev == 2'h1 && sync2 == 2'h0);
  assign rev = (prev == 2'h0 && sync2 == 2'h1) || (prev == 2'h1 && sync2 == 2'h3) ||
               (prev == 2'h3 && sync2 == 2'h2) || (prev == 2'h2 && sync2 == 2'h0);
  assign step_up = ce && fwd;
  assign step_dn = ce && rev;
endmodule

/* hdl/sifl_servo_loop.sv */
// Servo loop top: APB registers, position counter, integral and feed-forward datapath
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "sifl_params.svh"
module sifl_servo_loop
#(
  parameter int CYC_2MS   = `SIFL_T_2MS_NS / `SIFL_CLK_PERIOD_NS,
  parameter int CYC_1MS   = `SIFL_T_1MS_NS / `SIFL_CLK_PERIOD_NS,
  parameter int CYC_500US = `SIFL_T_500US_NS / `SIFL_CLK_PERIOD_NS,
  parameter int CYC_200US = `SIFL_T_200US_NS / `SIFL_CLK_PERIOD_NS,
  parameter int CYC_100US = `SIFL_T_100US_NS / `SIFL_CLK_PERIOD_NS
)
(
  input  wire logic                   MCLK,
  input  wire logic                   RSTN,
  input  wire logic                   CE,
  input  wire sifl_pkg::sifl_apb_req_t APB_REQ,
  output logic [31:0]                 PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  input  wire logic                   ENCODER_CHANNEL_A,
  input  wire logic                   ENCODER_CHANNEL_B,
  input  wire logic [31:0]            DEMAND_POSITION,
  input  wire logic [31:0]            DEMAND_VELOCITY,
  output logic [11:0]                 DAC_CODE,
  output logic                        SERVO_TICK
);
  // Refuse period counts that the 20-bit timer or the tick compare cannot serve
  if (CYC_100US < 2 || CYC_2MS >= (1 << 20) || CYC_1MS < CYC_500US || CYC_2MS < CYC_1MS)
  begin
    $error("sifl_servo_loop: unusable period counts");
  end

  sifl_pkg::sifl_gains_t gains;
  logic [31:0]  position;
  logic [31:0]  ferror;
  logic [31:0]  integ;
  logic [31:0]  vel_prev;
  logic [19:0]  per_cnt;
  logic [19:0]  since_tick;
  logic [11:0]  demand;
  logic [31:0]  next_prdata;
  logic         step_up;
  logic         step_dn;

  // =====================================================
  // Helpers
  function automatic logic [19:0] period_cycles(input sifl_pkg::sifl_period_t sel);
    logic [19:0] c;
    c = 20'(CYC_1MS);
    if (sel == `SIFL_PER_2MS)
      c = 20'(CYC_2MS);
    else if (sel == `SIFL_PER_500US)
      c = 20'(CYC_500US);
    else if (sel == `SIFL_PER_200US)
      c = 20'(CYC_200US);
    else if (sel == `SIFL_PER_100US)
      c = 20'(CYC_100US);
    return c;
  endfunction

  // Saturate a wide sum to the signed 12-bit output range
  function automatic logic [11:0] sat12(input logic signed [50:0] v);
    logic [11:0] r;
    r = v[11:0];
    if (v > 51'sd`SIFL_OUT_MAX)
      r = 12'h7ff;
    else if (v < -51'sd`SIFL_FULL_SCALE)
      r = 12'h800;
    return r;
  endfunction

  // =====================================================
  // Encoder
  sifl_quad_decoder u_quad
  (
    .clk     (MCLK),
    .rstn    (RSTN),
    .ce      (CE),
    .enc_a   (ENCODER_CHANNEL_A),
    .enc_b   (ENCODER_CHANNEL_B),
    .step_up (step_up),
    .step_dn (step_dn)
  );

  // =====================================================
  // APB decode
  wire        setup_ph  = APB_REQ.psel && !APB_REQ.penable;
  wire        access_ph = APB_REQ.psel && APB_REQ.penable;
  wire [11:0] addr      = APB_REQ.paddr;
  wire        hit_ctrl  = addr == `SIFL_OFS_CTRL;
  wire        hit_kp    = addr == `SIFL_OFS_PROPORTIONAL_GAIN;
  wire        hit_ki    = addr == `SIFL_OFS_INTEGRAL_GAIN;
  wire        hit_kc    = addr == `SIFL_OFS_KCLAMP;
  wire        hit_kv    = addr == `SIFL_OFS_KVFF;
  wire        hit_pos   = addr == `SIFL_OFS_POSITION;
  wire        hit_fe    = addr == `SIFL_OFS_FERROR;
  wire        hit_dem   = addr == `SIFL_OFS_DEMAND;
  wire        hit_int   = addr == `SIFL_OFS_INTEG;
  wire        hit_cmd   = addr == `SIFL_OFS_COMMAND;
  wire        mapped    = hit_ctrl | hit_kp | hit_ki | hit_kc | hit_kv | hit_pos | hit_fe | hit_dem
                          | hit_int | hit_cmd;
  wire        wr_en     = CE && access_ph && APB_REQ.pwrite && mapped;
  wire [31:0] wd        = APB_REQ.pwdata;
  wire        clr_integ = wr_en && hit_cmd && wd[`SIFL_CMD_CLR_INTEG];
  wire        clr_pos   = wr_en && hit_cmd && wd[`SIFL_CMD_CLR_POS];

  assign PREADY  = 1'b1;
  assign PSLVERR = access_ph && !mapped;

  wire [31:0] ctrl_rd = {25'h0, gains.period, 2'h0, gains.imode};
  assign next_prdata = hit_ctrl ? ctrl_rd :
                       hit_kp   ? {16'h0, gains.proportional_gain} :
                       hit_ki   ? {16'h0, gains.integral_gain} :
                       hit_kc   ? {24'h0, gains.clamp_pct} :
                       hit_kv   ? {16'h0, gains.kvff} :
                       hit_pos  ? position :
                       hit_fe   ? ferror :
                       hit_dem  ? {{20{demand[11]}}, demand} :
                       hit_int  ? integ : 32'h0;

  // =====================================================
  // Loop datapath, all combinational from registered state and the demand inputs
  wire        tick      = CE && (per_cnt >= period_cycles(gains.period) - 20'h1);
  wire [31:0] err_now   = DEMAND_POSITION - position;
  wire [6:0]  pct       = (gains.clamp_pct > 8'(`SIFL_PCT_FULL)) ? 7'(`SIFL_PCT_FULL) : gains.clamp_pct[6:0];
  wire signed [12:0] lim = 13'((32'(pct) * `SIFL_FULL_SCALE) / `SIFL_PCT_FULL);
  // Velocity demand arrives as counts per servo period, so no rescaling per period
  wire        vel_zero  = DEMAND_VELOCITY == 32'h0;
  wire        vel_const = DEMAND_VELOCITY == vel_prev;
  wire        i_apply   = (gains.imode == `SIFL_MODE_ALWAYS) ||
                          (gains.imode == `SIFL_MODE_SMART && (vel_zero || vel_const)) ||
                          (gains.imode == `SIFL_MODE_STEADY && vel_zero);
  wire signed [48:0] p_prod = $signed({1'b0, gains.proportional_gain}) * $signed(err_now);
  wire signed [48:0] i_prod = $signed({1'b0, gains.integral_gain}) * $signed(integ);
  wire signed [48:0] f_prod = $signed({1'b0, gains.kvff}) * $signed(DEMAND_VELOCITY);
  wire signed [48:0] i_raw  = i_prod >>> `SIFL_GAIN_FRAC;
  wire        i_hi      = i_raw > 49'(lim);
  wire        i_lo      = i_raw < -49'(lim);
  wire signed [12:0] i_clamped = i_hi ? lim : i_lo ? -lim : 13'(i_raw);
  wire signed [12:0] i_term    = i_apply ? i_clamped : 13'sh0;
  // Feed-forward enters after the loop terms, outside the closed loop
  wire signed [50:0] sum = 51'(p_prod >>> `SIFL_GAIN_FRAC) + 51'(i_term) + 51'(f_prod >>> `SIFL_GAIN_FRAC);
  wire [11:0] next_demand = sat12(sum);
  // Accumulation stops while the clamp holds and the error would push further: limits windup
  wire        err_neg   = err_now[31];
  wire        windup    = (i_hi && !err_neg) || (i_lo && err_neg);
  wire [31:0] next_integ = (i_apply && !windup) ? integ + err_now : integ;
  wire [31:0] next_pos  = (clr_pos ? 32'h0 : position) + (step_up ? 32'h1 : 32'h0) - (step_dn ? 32'h1 : 32'h0);

  // =====================================================
  // Registers
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      gains.proportional_gain     <= `SIFL_RST_GAIN;
      gains.integral_gain      <= `SIFL_RST_GAIN;
      gains.kvff      <= `SIFL_RST_GAIN;
      gains.clamp_pct <= `SIFL_RST_PCT;
      gains.imode     <= `SIFL_RST_MODE;
      gains.period    <= `SIFL_RST_PERIOD;
    end
    else if (wr_en)
    begin
      if (hit_ctrl)
      begin
        gains.imode  <= wd[`SIFL_CTRL_MODE_MSB:`SIFL_CTRL_MODE_LSB];
        gains.period <= wd[`SIFL_CTRL_PER_MSB:`SIFL_CTRL_PER_LSB];
      end
      if (hit_kp)
        gains.proportional_gain <= wd[15:0];
      if (hit_ki)
        gains.integral_gain <= wd[15:0];
      if (hit_kc)
        gains.clamp_pct <= wd[7:0];
      if (hit_kv)
        gains.kvff <= wd[15:0];
    end
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      position <= 32'h0;
      PRDATA   <= 32'h0;
    end
    else if (CE)
    begin
      position <= next_pos;
      if (setup_ph && !APB_REQ.pwrite)
        PRDATA <= next_prdata;
    end
  end

  // Servo period timer and sampled loop state
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      per_cnt    <= 20'h0;
      integ      <= 32'h0;
      vel_prev   <= 32'h0;
      ferror     <= 32'h0;
      demand     <= 12'h0;
      SERVO_TICK <= 1'b0;
    end
    else if (CE)
    begin
      SERVO_TICK <= tick;
      per_cnt    <= tick ? 20'h0 : per_cnt + 20'h1;
      if (tick)
      begin
        vel_prev <= DEMAND_VELOCITY;
        ferror   <= err_now;
        demand   <= next_demand;
      end
      // A clear takes priority over the sample in the same cycle
      if (clr_integ)
        integ <= 32'h0;
      else if (tick)
        integ <= next_integ;
    end
  end

  assign DAC_CODE = demand;

  // =====================================================
  // Assertions
  a_step_counts_up: assert property (@(posedge MCLK) disable iff (!RSTN)
    (step_up && !clr_pos) |=> position == $past(position) + 32'h1)
    else $error("position did not count up on encoder step");
  a_step_counts_dn: assert property (@(posedge MCLK) disable iff (!RSTN)
    (step_dn && !clr_pos) |=> position == $past(position) - 32'h1)
    else $error("position did not count down on encoder step");
  a_integ_only_tick: assert property (@(posedge MCLK) disable iff (!RSTN)
    (!tick && !clr_integ) |=> integ == $past(integ))
    else $error("integral changed outside a servo tick");
  a_integ_sums_err: assert property (@(posedge MCLK) disable iff (!RSTN)
    (tick && !clr_integ && gains.imode == `SIFL_MODE_ALWAYS && !windup) |=> integ == $past(integ) + $past(err_now))
    else $error("integral did not add following error");
  a_clamp_limit: assert property (@(posedge MCLK) disable iff (!RSTN)
    i_term <= lim && i_term >= -lim)
    else $error("integral term beyond clamp");
  a_mode_never_off: assert property (@(posedge MCLK) disable iff (!RSTN)
    (gains.imode == `SIFL_MODE_NEVER && tick) |=> integ == $past(integ) || $past(clr_integ))
    else $error("integral ran in never mode");
  a_steady_gate: assert property (@(posedge MCLK) disable iff (!RSTN)
    (gains.imode == `SIFL_MODE_STEADY && !vel_zero) |-> i_term == 13'sh0)
    else $error("integral applied while moving in steady mode");
  a_feedforward_only: assert property (@(posedge MCLK) disable iff (!RSTN)
    (tick && gains.proportional_gain == 16'h0 && i_term == 13'sh0) |=>
      DAC_CODE == sat12(51'($past(f_prod) >>> `SIFL_GAIN_FRAC)))
    else $error("feed-forward output wrong");
  a_zero_gain_out: assert property (@(posedge MCLK) disable iff (!RSTN)
    (tick && gains.proportional_gain == 16'h0 && gains.integral_gain == 16'h0 && gains.kvff == 16'h0) |=> DAC_CODE == 12'h0)
    else $error("output not zero with zero gains");
  a_dac_hold: assert property (@(posedge MCLK) disable iff (!RSTN)
    !tick |=> $stable(DAC_CODE))
    else $error("demand changed between ticks");
  // A low clock enable freezes the pulse as well, so only enabled cycles count
  a_tick_pulse: assert property (@(posedge MCLK) disable iff (!RSTN)
    (SERVO_TICK && CE) |=> !SERVO_TICK)
    else $error("servo tick longer than one cycle");
  a_pos_hold: assert property (@(posedge MCLK) disable iff (!RSTN)
    (!step_up && !step_dn && !clr_pos) |=> position == $past(position))
    else $error("position moved without an encoder step");
  a_ferror_latch: assert property (@(posedge MCLK) disable iff (!RSTN)
    tick |=> ferror == $past(err_now))
    else $error("following error not latched at tick");
  a_never_gate: assert property (@(posedge MCLK) disable iff (!RSTN)
    gains.imode == `SIFL_MODE_NEVER |-> i_term == 13'sh0)
    else $error("integral applied in never mode");
  a_smart_gate: assert property (@(posedge MCLK) disable iff (!RSTN)
    (gains.imode == `SIFL_MODE_SMART && !vel_zero && !vel_const) |-> i_term == 13'sh0)
    else $error("integral applied while speed changes in smart mode");
  a_clamp_hold: assert property (@(posedge MCLK) disable iff (!RSTN)
    (tick && windup && !clr_integ) |=> integ == $past(integ))
    else $error("integral wound up past the clamp");
  a_ce_freeze: assert property (@(posedge MCLK) disable iff (!RSTN)
    !CE |=> position == $past(position) && integ == $past(integ) && per_cnt == $past(per_cnt)
            && DAC_CODE == $past(DAC_CODE))
    else $error("state moved while clock enable low");

  // =====================================================
  // Tick spacing watch: no servo period may outrun the longest setting
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      since_tick <= 20'h0;
    else if (CE)
      since_tick <= SERVO_TICK ? 20'h1 : since_tick + 20'h1;
  end
  a_period_bound: assert property (@(posedge MCLK) disable iff (!RSTN)
    since_tick <= 20'(CYC_2MS))
    else $error("servo period longer than the longest setting");

  c_enc_up:   cover property (@(posedge MCLK) disable iff (!RSTN) step_up ##[1:20] step_up);
  c_clamped:  cover property (@(posedge MCLK) disable iff (!RSTN) tick && i_hi && i_apply);
  c_sat_pos:  cover property (@(posedge MCLK) disable iff (!RSTN) tick ##1 DAC_CODE == 12'h7ff);
  c_smart:    cover property (@(posedge MCLK) disable iff (!RSTN) tick && gains.imode == `SIFL_MODE_SMART && i_apply);
  c_ce_low:   cover property (@(posedge MCLK) disable iff (!RSTN) !CE ##1 CE);
endmodule

/* testbench/sifl_encoder_model.sv */
// Behavioural quadrature encoder that drives the two channel pins
`timescale 1ns/1ps
module sifl_encoder_model
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       go,
  input  wire logic       dir,
  input  wire logic [7:0] count,
  output logic            enc_a,
  output logic            enc_b,
  output logic            busy
);
  logic [1:0] phase;
  logic [7:0] left;
  logic [1:0] hold;
  // ==========================================
  // Stepping
  // Each state stands four cycles, above the two-cycle minimum of the synchroniser
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase <= 2'h0;
      left  <= 8'h00;
      hold  <= 2'h0;
    end
    else if (go)
    begin
      left <= count;
      hold <= 2'h0;
    end
    else if (left != 8'h00)
    begin
      hold <= hold + 2'h1;
      if (hold == 2'h3)
      begin
        phase <= dir ? phase + 2'h1 : phase - 2'h1;
        left  <= left - 8'h01;
      end
    end
  end
  // Gray order 00, 10, 11, 01 in {A,B}: A leads B when counting up
  assign enc_a = phase[1] ^ phase[0];
  assign enc_b = phase[1];
  assign busy  = (left != 8'h00);
endmodule

/* testbench/sifl_servo_loop_tb_top.sv */
// Self-checking bench for the servo loop top
`timescale 1ns/1ps
`include "sifl_params.svh"
module sifl_servo_loop_tb_top;
  logic                    MCLK;
  logic                    RSTN;
  sifl_pkg::sifl_apb_req_t req;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    enc_a;
  logic                    enc_b;
  logic [31:0]             dpos;
  logic [31:0]             dvel;
  logic [11:0]             dac;
  logic                    tick;
  logic                    go;
  logic                    dir;
  logic [7:0]              cnt;
  logic                    busy;
  logic                    ce;
  logic [31:0]             rd;
  logic                    er;
  logic [11:0]             d1;
  int                      n;
  int                      num_errors;
  int                      checks_done;

  // Short periods keep the run small; expectations use the same figures
  sifl_servo_loop #(.CYC_2MS(80), .CYC_1MS(40), .CYC_500US(20), .CYC_200US(8), .CYC_100US(4)) u_dut (
    .MCLK(MCLK), .RSTN(RSTN), .CE(ce), .APB_REQ(req), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .ENCODER_CHANNEL_A(enc_a), .ENCODER_CHANNEL_B(enc_b), .DEMAND_POSITION(dpos),
    .DEMAND_VELOCITY(dvel), .DAC_CODE(dac), .SERVO_TICK(tick));
  sifl_encoder_model u_enc (.clk(MCLK), .rstn(RSTN), .go(go), .dir(dir), .count(cnt),
    .enc_a(enc_a), .enc_b(enc_b), .busy(busy));

  // ==========================================
  // Shared tasks
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic timeout(input string what);
    num_errors++;
    $display("MISMATCH at %0t: timeout in %s", $time, what);
    report_and_stop();
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge MCLK);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge MCLK);
    req.penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge MCLK);
      k++;
      if (k > 20)
        timeout("apb");
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "register read");
  endtask
  // Counts the cycles up to the next tick in n
  task automatic wait_tick();
    n = 0;
    do
    begin
      @(posedge MCLK);
      #1;
      n++;
      if (n > 300)
        timeout("tick");
    end
    while (tick !== 1'b1);
  endtask
  task automatic set_in(input logic [31:0] p, input logic [31:0] v);
    @(posedge MCLK);
    dpos <= p;
    dvel <= v;
  endtask
  // The first tick after a change may mix old and new settings, so it is skipped
  task automatic tick_dac(input logic [11:0] exp);
    wait_tick();
    wait_tick();
    chk(dac, exp, "demand code");
  endtask
  task automatic per_chk(input logic [2:0] code, input int cyc);
    wr(`SIFL_OFS_CTRL, {25'h0, code, 4'h1});
    wait_tick();
    wait_tick();
    chk(n, cyc, "period");
  endtask
  task automatic move(input logic up, input logic [7:0] c);
    int k;
    @(posedge MCLK);
    go <= 1'b1;
    dir <= up;
    cnt <= c;
    @(posedge MCLK);
    go <= 1'b0;
    k = 0;
    do
    begin
      @(posedge MCLK);
      k++;
      if (k > 500)
        timeout("encoder");
    end
    while (busy === 1'b1);
    repeat (6) @(posedge MCLK);
  endtask
  // Freezes the block for 20 edges right after a tick; one period count ran before it
  task automatic ce_freeze();
    wait_tick();
    @(posedge MCLK);
    ce <= 1'b0;
    repeat (20) @(posedge MCLK);
    ce <= 1'b1;
    wait_tick();
    chk(n, 7, "period across clock enable low");
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end
  initial
  begin
    RSTN = 1'b0;
    req = '0;
    dpos = 32'h0;
    dvel = 32'h0;
    go = 1'b0;
    ce = 1'b1;
    dir = 1'b0;
    cnt = 8'h00;
    num_errors = 0;
    checks_done = 0;
    repeat (20) @(posedge MCLK);
    RSTN <= 1'b1;
    rdchk(`SIFL_OFS_CTRL, 32'h1);
    for (int a = 4; a <= 16; a += 4)
      rdchk(a[11:0], 32'h0);
    wait_tick();
    chk(dac, 32'h0, "dac after reset");
    wait_tick();
    chk(n, 40, "default period");
    per_chk(3'h1, 80);
    per_chk(3'h2, 20);
    per_chk(3'h4, 4);
    per_chk(3'h5, 40);
    per_chk(3'h3, 8);
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    wr(`SIFL_OFS_COMMAND, 32'h2);
    move(1'b1, 8'h08);
    rdchk(`SIFL_OFS_POSITION, 32'h8);
    move(1'b0, 8'h03);
    rdchk(`SIFL_OFS_POSITION, 32'h5);
    wr(`SIFL_OFS_COMMAND, 32'h2);
    rdchk(`SIFL_OFS_POSITION, 32'h0);
    wr(`SIFL_OFS_CTRL, 32'h30);
    wr(`SIFL_OFS_PROPORTIONAL_GAIN, 32'h100);
    set_in(32'h64, 32'h0);
    tick_dac(12'h064);
    rdchk(`SIFL_OFS_FERROR, 32'h64);
    set_in(32'hffffffd8, 32'h0);
    tick_dac(12'hfd8);
    rdchk(`SIFL_OFS_DEMAND, 32'hffffffd8);
    set_in(32'h1388, 32'h0);
    tick_dac(12'h7ff);
    set_in(32'hffffec78, 32'h0);
    tick_dac(12'h800);
    wr(`SIFL_OFS_PROPORTIONAL_GAIN, 32'h0);
    wr(`SIFL_OFS_KVFF, 32'h200);
    set_in(32'h0, 32'h12c);
    tick_dac(12'h258);
    set_in(32'h0, 32'hffffffce);
    tick_dac(12'hf9c);
    wr(`SIFL_OFS_KVFF, 32'h0);
    wr(`SIFL_OFS_INTEGRAL_GAIN, 32'h100);
    wr(`SIFL_OFS_KCLAMP, 32'h5);
    set_in(32'h1e, 32'h0);
    wr(`SIFL_OFS_CTRL, 32'h31);
    wr(`SIFL_OFS_COMMAND, 32'h1);
    wait_tick();
    wait_tick();
    d1 = dac;
    wait_tick();
    chk(dac - d1, 32'h1e, "integral step");
    repeat (8) wait_tick();
    chk(dac, 32'h66, "integral clamp");
    rdchk(`SIFL_OFS_INTEG, 32'h78);
    wr(`SIFL_OFS_CTRL, 32'h30);
    tick_dac(12'h000);
    set_in(32'h1e, 32'h5);
    wr(`SIFL_OFS_CTRL, 32'h33);
    tick_dac(12'h000);
    set_in(32'h1e, 32'h0);
    tick_dac(12'h066);
    set_in(32'h1e, 32'h7);
    wr(`SIFL_OFS_CTRL, 32'h32);
    tick_dac(12'h066);
    set_in(32'h1e, 32'h8);
    wait_tick();
    chk(dac, 32'h0, "changing speed");
    ce_freeze();
    report_and_stop();
  end
endmodule
